// ---- logic/cra_defs.svh ----
`ifndef CRA_DEFS_SVH
`define CRA_DEFS_SVH

// ----------------------------------------------------------------
// Command locations
// ----------------------------------------------------------------
`define CRA_CMD_SUBCLASS 8'h3E
`define CRA_CMD_BLOCK 8'h3F
`define CRA_CMD_BUF_FIRST 8'h40
`define CRA_CMD_BUF_LAST 8'h5F
`define CRA_CMD_CHAL_SUM 8'h54
`define CRA_CMD_BLOCK_SUM 8'h60
`define CRA_CMD_ACCESS 8'h61
`define CRA_CMD_MAX 8'h7F

// ----------------------------------------------------------------
// Field values and layout
// ----------------------------------------------------------------
`define CRA_ACCESS_KEY 8'h00
`define CRA_ACCESS_AUTH 8'h01
`define CRA_KEY_SUBCLASS 8'h70
`define CRA_KEY_BLOCK 8'h00
`define CRA_KEY_FIRST 12
`define CRA_KEY_LAST 27
`define CRA_CHAL_BYTES 20
`define CRA_BUF_BYTES 32

// ----------------------------------------------------------------
// Reset values and hash constants
// ----------------------------------------------------------------
`define CRA_DEFAULT_KEY 128'h0123456789ABCDEFFEDCBA987654321
`define CRA_SEL_RESET 8'h00
`define CRA_IPAD 8'h36
`define CRA_OPAD 8'h5C
`define CRA_PAD_LEN 64'h00000000000002A0
`define CRA_SHA_IV 160'h67452301EFCDAB8998BADCFE10325476C3D2E1F0
`define CRA_SHA_LAST_ROUND 7'h4F

`endif

// ---- logic/cra_pkg.sv ----
package cra_pkg;

  typedef enum logic [4:0] {
    CRA_ST_IDLE = 5'b00001,
    CRA_ST_IN1 = 5'b00010,
    CRA_ST_IN2 = 5'b00100,
    CRA_ST_OUT1 = 5'b01000,
    CRA_ST_OUT2 = 5'b10000
  } cra_state_t;

  typedef logic [0:31][7:0] cra_buf_t;
  typedef logic [0:15][31:0] cra_sched_t;

endpackage : cra_pkg

// ---- logic/cra_sha1_core.sv ----
`timescale 1ns/1ps
`include "cra_defs.svh"

module cra_sha1_core import cra_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic chain,
  input wire logic [511:0] block,
  output logic done,
  output logic [159:0] digest
);

  logic [31:0] a_reg, b_reg, c_reg, d_reg, e_reg;
  cra_sched_t w_reg;
  logic [6:0] rnd_reg;
  logic run_reg;
  logic [31:0] f_c, k_c, t_c, w_next;
  logic [159:0] h_base;

  function automatic logic [31:0] rol(input logic [31:0] x,
                                      input int n);
    rol = (x << n) | (x >> (32 - n));
  endfunction : rol

  assign h_base = chain ? digest : `CRA_SHA_IV;

  // ----------------------------------------------------------------
  // Round function, one round per cycle
  // ----------------------------------------------------------------
  always_comb begin
    if (rnd_reg < 7'd20) begin
      f_c = (b_reg & c_reg) | (~b_reg & d_reg);
      k_c = 32'h5A827999;
    end else if (rnd_reg < 7'd40) begin
      f_c = b_reg ^ c_reg ^ d_reg;
      k_c = 32'h6ED9EBA1;
    end else if (rnd_reg < 7'd60) begin
      f_c = (b_reg & c_reg) | (b_reg & d_reg) | (c_reg & d_reg);
      k_c = 32'h8F1BBCDC;
    end else begin
      f_c = b_reg ^ c_reg ^ d_reg;
      k_c = 32'hCA62C1D6;
    end
    t_c = rol(a_reg, 5) + f_c + e_reg + k_c + w_reg[0];
    w_next = rol(w_reg[13] ^ w_reg[8] ^ w_reg[2] ^ w_reg[0], 1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_reg <= 32'h0;
      b_reg <= 32'h0;
      c_reg <= 32'h0;
      d_reg <= 32'h0;
      e_reg <= 32'h0;
      w_reg <= '0;
      rnd_reg <= 7'h0;
      run_reg <= 1'b0;
      done <= 1'b0;
      digest <= 160'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        digest <= h_base;
        {a_reg, b_reg, c_reg, d_reg, e_reg} <= h_base;
        w_reg <= block;
        rnd_reg <= 7'h0;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        a_reg <= t_c;
        b_reg <= a_reg;
        c_reg <= rol(b_reg, 30);
        d_reg <= c_reg;
        e_reg <= d_reg;
        w_reg <= {w_reg[1:15], w_next};
        rnd_reg <= rnd_reg + 7'd1;
        if (rnd_reg == `CRA_SHA_LAST_ROUND) begin
          run_reg <= 1'b0;
          done <= 1'b1;
          digest <= {digest[159:128] + t_c, digest[127:96] + a_reg,
                     digest[95:64] + rol(b_reg, 30),
                     digest[63:32] + c_reg, digest[31:0] + d_reg};
        end
      end
    end
  end

endmodule : cra_sha1_core

// ---- logic/cra_auth.sv ----
`timescale 1ns/1ps
`include "cra_defs.svh"

module cra_auth import cra_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic access_open,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_addr,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  output logic wr_ack,
  output logic rd_ack,
  output logic rd_nack,
  output logic [7:0] rd_data,
  output logic busy
);

  cra_buf_t buf_reg;
  logic [127:0] key_reg;
  logic [7:0] ptr_reg;
  logic [7:0] access_reg;
  logic [7:0] subclass_reg;
  logic [7:0] block_reg;
  logic auth_en_reg;
  cra_state_t state_reg;
  logic core_start_reg;
  logic [159:0] inner_reg;
  logic core_done;
  logic [159:0] core_digest;
  logic [511:0] core_block;
  logic core_chain;
  logic key_mode;
  logic in_buf;
  logic wr_buf;
  logic [7:0] buf_idx;
  logic chal_ok;
  logic key_ok;

  function automatic logic [7:0] csum(input cra_buf_t b, input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < `CRA_BUF_BYTES; i++) begin
      if (i < n) begin
        s = s + b[i];
      end
    end
    csum = 8'hFF - s;
  endfunction : csum

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign key_mode = access_open && access_reg == `CRA_ACCESS_KEY
                    && subclass_reg == `CRA_KEY_SUBCLASS
                    && block_reg == `CRA_KEY_BLOCK;
  assign in_buf = ptr_reg >= `CRA_CMD_BUF_FIRST
                  && ptr_reg <= `CRA_CMD_BUF_LAST;
  assign buf_idx = ptr_reg - `CRA_CMD_BUF_FIRST;
  // Buffer is frozen while hashing so the digest cannot be corrupted
  assign wr_buf = wr_stb && in_buf && !busy;
  assign chal_ok = wr_stb && ptr_reg == `CRA_CMD_CHAL_SUM && auth_en_reg
                   && !busy
                   && wr_data == csum(buf_reg, `CRA_CHAL_BYTES);
  assign key_ok = wr_stb && ptr_reg == `CRA_CMD_BLOCK_SUM && key_mode
                  && !busy
                  && wr_data == csum(buf_reg, `CRA_BUF_BYTES);

  // ----------------------------------------------------------------
  // Pointer and select registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= 8'h00;
    end else if (cmd_start) begin
      ptr_reg <= cmd_addr;
    end else if (wr_stb || (rd_stb && ptr_reg <= `CRA_CMD_MAX)) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access_reg <= `CRA_SEL_RESET;
      subclass_reg <= `CRA_SEL_RESET;
      block_reg <= `CRA_SEL_RESET;
      auth_en_reg <= 1'b0;
    end else if (wr_stb) begin
      if (ptr_reg == `CRA_CMD_ACCESS) begin
        access_reg <= wr_data;
        auth_en_reg <= access_open && wr_data == `CRA_ACCESS_AUTH;
      end else if (ptr_reg == `CRA_CMD_SUBCLASS) begin
        subclass_reg <= wr_data;
      end else if (ptr_reg == `CRA_CMD_BLOCK) begin
        block_reg <= wr_data;
        if (!access_open && wr_data == `CRA_KEY_BLOCK) begin
          auth_en_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Key store
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_reg <= `CRA_DEFAULT_KEY;
    end else if (key_ok) begin
      key_reg <= buf_reg[`CRA_KEY_FIRST:`CRA_KEY_LAST];
    end
  end

  // ----------------------------------------------------------------
  // Buffer: host bytes and digest write-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_reg <= '0;
    end else if (core_done && state_reg == CRA_ST_OUT2) begin
      for (int i = 0; i < `CRA_CHAL_BYTES; i++) begin
        buf_reg[i] <= core_digest[159 - 8 * i -: 8];
      end
    end else if (wr_buf) begin
      buf_reg[buf_idx[4:0]] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // HMAC sequencer: inner key, inner message, outer key, outer digest
  // ----------------------------------------------------------------
  always_comb begin
    core_chain = state_reg == CRA_ST_IN2 || state_reg == CRA_ST_OUT2;
    case (state_reg)
      CRA_ST_IN1: begin
        core_block = {key_reg, 384'h0} ^ {64{`CRA_IPAD}};
      end
      CRA_ST_IN2: begin
        core_block = {buf_reg[0:19], 8'h80, 280'h0, `CRA_PAD_LEN};
      end
      CRA_ST_OUT1: begin
        core_block = {key_reg, 384'h0} ^ {64{`CRA_OPAD}};
      end
      CRA_ST_OUT2: begin
        core_block = {inner_reg, 8'h80, 280'h0, `CRA_PAD_LEN};
      end
      default: begin
        core_block = 512'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CRA_ST_IDLE;
      core_start_reg <= 1'b0;
      inner_reg <= 160'h0;
      busy <= 1'b0;
    end else begin
      core_start_reg <= 1'b0;
      case (state_reg)
        CRA_ST_IDLE: begin
          if (chal_ok) begin
            state_reg <= CRA_ST_IN1;
            core_start_reg <= 1'b1;
            busy <= 1'b1;
          end
        end
        CRA_ST_IN1: begin
          if (core_done) begin
            state_reg <= CRA_ST_IN2;
            core_start_reg <= 1'b1;
          end
        end
        CRA_ST_IN2: begin
          if (core_done) begin
            inner_reg <= core_digest;
            state_reg <= CRA_ST_OUT1;
            core_start_reg <= 1'b1;
          end
        end
        CRA_ST_OUT1: begin
          if (core_done) begin
            state_reg <= CRA_ST_OUT2;
            core_start_reg <= 1'b1;
          end
        end
        CRA_ST_OUT2: begin
          if (core_done) begin
            state_reg <= CRA_ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= CRA_ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  cra_sha1_core u_core (
    .clk(clk),
    .rstn(rstn),
    .start(core_start_reg),
    .chain(core_chain),
    .block(core_block),
    .done(core_done),
    .digest(core_digest)
  );

  // ----------------------------------------------------------------
  // Read and write answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
      rd_ack <= 1'b0;
      rd_nack <= 1'b0;
      wr_ack <= 1'b0;
    end else begin
      wr_ack <= wr_stb;
      rd_ack <= rd_stb && ptr_reg <= `CRA_CMD_MAX;
      rd_nack <= rd_stb && ptr_reg > `CRA_CMD_MAX;
      if (rd_stb) begin
        if (in_buf) begin
          rd_data <= buf_reg[buf_idx[4:0]];
        end else if (ptr_reg == `CRA_CMD_ACCESS) begin
          rd_data <= access_reg;
        end else if (ptr_reg == `CRA_CMD_SUBCLASS) begin
          rd_data <= subclass_reg;
        end else if (ptr_reg == `CRA_CMD_BLOCK) begin
          rd_data <= block_reg;
        end else begin
          rd_data <= 8'h00;
        end
      end
    end
  end

endmodule : cra_auth

// ---- bench/cra_auth_assertions.sv ----
`timescale 1ns/1ps
module cra_auth_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic access_open,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_addr,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic wr_ack,
  input wire logic rd_ack,
  input wire logic rd_nack,
  input wire logic [7:0] rd_data,
  input wire logic busy
);
  // ------------------------------------------------------------
  // Pointer shadow
  // ------------------------------------------------------------
  logic [7:0] ptr_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ptr_reg <= 8'h00;
    else if (cmd_start) ptr_reg <= cmd_addr;
    else if (wr_stb || (rd_stb && ptr_reg <= 8'h7F))
      ptr_reg <= ptr_reg + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  wr_ack_a: assert property (
    wr_stb |=> wr_ack) else $error("write not acked");
  rd_ack_a: assert property (
    rd_stb && ptr_reg <= 8'h7F |=> rd_ack && !rd_nack)
    else $error("read not acked");
  rd_nack_a: assert property (
    rd_stb && ptr_reg > 8'h7F |=> rd_nack && !rd_ack)
    else $error("high read not refused");
  no_spur_a: assert property (
    !rd_stb |=> !rd_ack && !rd_nack) else $error("stray read answer");
  ack_cause_a: assert property (
    wr_ack |-> $past(wr_stb)) else $error("stray write ack");
  busy_start_a: assert property (
    $rose(busy) |-> $past(wr_stb) && $past(ptr_reg) == 8'h54)
    else $error("hash began without sum write");
  busy_end_a: assert property (
    $rose(busy) |-> ##[1:340] !busy) else $error("hash too long");
  rd_hold_a: assert property (
    !rd_stb |=> $stable(rd_data)) else $error("read data moved");
endmodule : cra_auth_chk

bind cra_auth cra_auth_chk cra_auth_chk_i (.clk(clk), .rstn(rstn),
  .access_open(access_open), .cmd_start(cmd_start), .cmd_addr(cmd_addr),
  .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .wr_ack(wr_ack),
  .rd_ack(rd_ack), .rd_nack(rd_nack), .rd_data(rd_data), .busy(busy));

// ---- bench/cra_host.sv ----
`timescale 1ns/1ps
module cra_host (
  input wire logic clk,
  output logic access_open,
  output logic cmd_start,
  output logic [7:0] cmd_addr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  input wire logic wr_ack,
  input wire logic rd_ack,
  input wire logic rd_nack,
  input wire logic [7:0] rd_data
);
  initial begin
    access_open <= 1'b1;
    cmd_start <= 1'b0;
    cmd_addr <= 8'h00;
    wr_stb <= 1'b0;
    wr_data <= 8'h00;
    rd_stb <= 1'b0;
  end
  // ------------------------------------------------------------
  // Reference digest the host computes on its own side
  // ------------------------------------------------------------
  function automatic logic [159:0] sha_blk(input logic [159:0] h,
                                           input logic [511:0] m);
    logic [31:0] w [0:79];
    logic [31:0] va, vb, vc, vd, ve, f, k, t, x;
    for (int i = 0; i < 16; i++) w[i] = m[511 - 32 * i -: 32];
    for (int i = 16; i < 80; i++) begin
      x = w[i - 3] ^ w[i - 8] ^ w[i - 14] ^ w[i - 16];
      w[i] = {x[30:0], x[31]};
    end
    {va, vb, vc, vd, ve} = h;
    for (int i = 0; i < 80; i++) begin
      if (i < 20) begin
        f = (vb & vc) | (~vb & vd);
        k = 32'h5A827999;
      end else if (i < 40) begin
        f = vb ^ vc ^ vd;
        k = 32'h6ED9EBA1;
      end else if (i < 60) begin
        f = (vb & vc) | (vb & vd) | (vc & vd);
        k = 32'h8F1BBCDC;
      end else begin
        f = vb ^ vc ^ vd;
        k = 32'hCA62C1D6;
      end
      t = {va[26:0], va[31:27]} + f + ve + k + w[i];
      ve = vd;
      vd = vc;
      vc = {vb[1:0], vb[31:2]};
      vb = va;
      va = t;
    end
    sha_blk = {h[159:128] + va, h[127:96] + vb, h[95:64] + vc,
               h[63:32] + vd, h[31:0] + ve};
  endfunction : sha_blk
  // Key is zero padded to one block; both messages are 84 bytes long
  function automatic logic [159:0] hmac_ref(input logic [127:0] key,
                                            input logic [159:0] msg);
    logic [511:0] kb;
    logic [159:0] iv;
    logic [159:0] inner;
    logic [159:0] outer;
    kb = {key, 384'h0};
    iv = 160'h67452301EFCDAB8998BADCFE10325476C3D2E1F0;
    inner = sha_blk(iv, kb ^ {64{8'h36}});
    inner = sha_blk(inner, {msg, 8'h80, 280'h0, 64'h2A0});
    outer = sha_blk(iv, kb ^ {64{8'h5C}});
    outer = sha_blk(outer, {inner, 8'h80, 280'h0, 64'h2A0});
    hmac_ref = outer;
  endfunction : hmac_ref
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic mode(input logic o);
    @(posedge clk);
    access_open <= o;
  endtask : mode
  task automatic set_ptr(input logic [7:0] a);
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_addr <= a;
    @(posedge clk);
    cmd_start <= 1'b0;
    cmd_addr <= ~a; // Released address must not look valid
  endtask : set_ptr
  task automatic wr(input logic [7:0] d, output logic ok);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
    #1 ok = wr_ack;
  endtask : wr
  task automatic rd(output logic [7:0] d, output logic ak, output logic nk);
    @(posedge clk);
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
    ak = rd_ack;
    nk = rd_nack;
  endtask : rd
endmodule : cra_host

// ---- bench/cra_auth_tb.sv ----
`timescale 1ns/1ps
module cra_auth_tb;
  import cra_pkg::*;
  logic clk, rstn, access_open, cmd_start, wr_stb, rd_stb;
  logic wr_ack, rd_ack, rd_nack, busy, a, k, n;
  logic [7:0] cmd_addr, wr_data, rd_data, d;
  int n_errors = 0;
  int checked = 0;
  localparam logic [127:0] key_default =
    128'h0123456789ABCDEFFEDCBA987654321;
  cra_auth cra_auth_i (.clk(clk), .rstn(rstn), .access_open(access_open),
    .cmd_start(cmd_start), .cmd_addr(cmd_addr), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .wr_ack(wr_ack), .rd_ack(rd_ack),
    .rd_nack(rd_nack), .rd_data(rd_data), .busy(busy));
  cra_host cra_host_i (.clk(clk), .access_open(access_open),
    .cmd_start(cmd_start), .cmd_addr(cmd_addr), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .wr_ack(wr_ack), .rd_ack(rd_ack),
    .rd_nack(rd_nack), .rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Challenge bytes are 0..19, so a good sum is 0xFF - 0xBE = 0x41
  task automatic send_chal(input logic [7:0] sum);
    cra_host_i.set_ptr(8'h40);
    for (int i = 0; i < 20; i++) cra_host_i.wr(8'(i), a);
    cra_host_i.wr(sum, a);
  endtask : send_chal
  task automatic wait_idle;
    int c;
    c = 0;
    while (busy === 1'b1 && c < 340) begin
      @(posedge clk);
      c++;
    end
    #1 chk("busy end", 8'h00, {7'h00, busy});
    if (busy !== 1'b0) print_verdict();
  endtask : wait_idle
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    cra_host_i.set_ptr(8'h3E);
    cra_host_i.wr(8'h70, a);
    chk("wr ack", 8'h01, {7'h00, a});
    cra_host_i.wr(8'h00, a);
    cra_host_i.set_ptr(8'h3E);
    cra_host_i.rd(d, k, n);
    chk("subclass", 8'h70, d);
    cra_host_i.rd(d, k, n);
    chk("block", 8'h00, d);
    cra_host_i.set_ptr(8'h80);
    cra_host_i.rd(d, k, n);
    chk("nack", 8'h01, {7'h00, n});
    chk("ack", 8'h00, {7'h00, k});
    $display("test regs done");
  endtask : t_regs
  task automatic t_bad_sum;
    cra_host_i.mode(1'b1);
    cra_host_i.set_ptr(8'h61);
    cra_host_i.wr(8'h01, a);
    send_chal(8'h42);
    repeat (5) @(posedge clk);
    #1 chk("busy bad", 8'h00, {7'h00, busy});
    $display("test bad sum done");
  endtask : t_bad_sum
  task automatic t_auth(input logic open, input logic [127:0] key);
    int same;
    logic [159:0] m;
    logic [159:0] dig_exp;
    same = 0;
    m = '0;
    for (int i = 0; i < 20; i++) m = {m[151:0], 8'(i)};
    dig_exp = cra_host_i.hmac_ref(key, m);
    cra_host_i.mode(open);
    if (open) cra_host_i.set_ptr(8'h61);
    else cra_host_i.set_ptr(8'h3F);
    cra_host_i.wr(open ? 8'h01 : 8'h00, a);
    send_chal(8'h41);
    chk("busy go", 8'h01, {7'h00, busy});
    wait_idle();
    cra_host_i.set_ptr(8'h40);
    for (int i = 0; i < 20; i++) begin
      cra_host_i.rd(d, k, n);
      if (d === 8'(i)) same++;
      chk("digest byte", dig_exp[159 - 8 * i -: 8], d);
    end
    chk("replaced", 8'h01, {7'h00, same < 20});
    $display("test auth done");
  endtask : t_auth
  // Key bytes are 0..31, so a good block sum is 0xFF - 0xF0 = 0x0F
  task automatic load_key(input logic open, input logic [7:0] sum);
    cra_host_i.mode(open);
    cra_host_i.set_ptr(8'h61);
    cra_host_i.wr(8'h00, a);
    cra_host_i.set_ptr(8'h3E);
    cra_host_i.wr(8'h70, a);
    cra_host_i.wr(8'h00, a);
    cra_host_i.set_ptr(8'h40);
    for (int i = 0; i < 32; i++) cra_host_i.wr(8'(i), a);
    cra_host_i.wr(sum, a);
  endtask : load_key
  task automatic t_key;
    load_key(1'b0, 8'h0F);
    t_auth(1'b1, key_default);
    load_key(1'b1, 8'h10);
    t_auth(1'b1, key_default);
    load_key(1'b1, 8'h0F);
    t_auth(1'b1, 128'h0C0D0E0F101112131415161718191A1B);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("busy rst", 8'h00, {7'h00, busy});
    t_auth(1'b1, key_default);
    $display("test key done");
  endtask : t_key
  initial begin
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_bad_sum();
    t_auth(1'b1, key_default);
    t_auth(1'b0, key_default);
    t_key();
    print_verdict();
  end
endmodule : cra_auth_tb
